// File: rtl/rshb_ctrl.sv
// Reset, self-test selection and bus hold control of the processor
//
// Contract
// - On bus request, raise grant, float bus and control, enter held state.
// - When request drops, drop grant, go idle or address, drive bus again.
// - Grant bus requests during reset, while halted and in normal operation.
// - Stall warning high when a stall may come, low otherwise.
// - Core and bus run on the input clock, all on its rising edge.
// - During reset clear internal logic, hold bus and control outputs idle; code leaves bus state, grant, pin regs unreset, a grant floats the pins.
// - In reset ignore inputs but lock/debug, self-test select, request.
// - Reset input passes an internal synchronizer before use.
// - Sample self-test select at end of reset to choose the tests.
// - Self-test select high: run self-test then bus confidence test.
// - Self-test select low: skip self-test, run bus confidence test only.
// - Lock/debug pin low at end of reset: stop and float all outputs; code floats bus, control, lock pins, not grant, stall, fail.
// - Never grant a bus request while the lock output is driven.
// - Fail output asserted at reset, cleared on pass, kept and stop on fail.
`timescale 1ns/10ps

module rshb_ctrl (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  bus_req,
  input  wire logic                  selftest_select,
  input  wire logic                  atomic_lock_debug_pin_in,
  input  wire logic                  core_lock,
  input  wire logic                  core_halted,
  input  wire logic                  core_bus_pending,
  input  wire logic                  core_addr_start,
  input  wire logic                  selftest_ok,
  input  wire logic                  conftest_ok,
  input  wire rshb_pkg::rshb_busreq_t core_bus,
  output logic                       bus_grant_ack,
  output logic                       stall_warning,
  output logic                       atomic_lock_debug_pin_out,
  output logic                       atomic_lock_debug_pin_oe,
  output logic                       fail_n,
  output logic                       core_run,
  output logic                       core_reset,
  output logic                       debug_mode,
  output logic                       selftest_active,
  output logic                       conftest_active,
  output rshb_pkg::rshb_buspin_t     bus_pins
);

  // Reset release synchronizer; assertion stays asynchronous
  logic [1:0] rst_sync_reg;
  logic       rst_sync_n;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_sync_n = rst_sync_reg[1];

  // Pin inputs pass three flops; a change counts when the last two agree
  logic [2:0] req_sync_reg;
  logic [2:0] st_sync_reg;
  logic [2:0] lk_sync_reg;
  logic       req_reg;
  logic       st_reg;
  logic       lk_reg;
  logic       req_next;
  logic       st_next;
  logic       lk_next;

  function automatic logic settle(input logic [2:0] s, input logic prev);
    settle = (s[2] == s[1]) ? s[2] : prev;
  endfunction

  // Only request, self-test select and lock/debug are watched in reset;
  // these flops have no reset so they keep sampling while reset is held
  // and carry settled pin levels at its end
  always_ff @(posedge clk)
  begin
    req_sync_reg <= {req_sync_reg[1:0], bus_req};
    st_sync_reg  <= {st_sync_reg[1:0], selftest_select};
    lk_sync_reg  <= {lk_sync_reg[1:0], atomic_lock_debug_pin_in};
    req_reg      <= req_next;
    st_reg       <= st_next;
    lk_reg       <= lk_next;
  end

  always_comb
  begin
    req_next = settle(req_sync_reg, req_reg);
    st_next  = settle(st_sync_reg, st_reg);
    lk_next  = settle(lk_sync_reg, lk_reg);
  end

  // Reset hold is raw reset low or the synchronized copy not yet released
  logic in_reset;
  assign in_reset = !rst_sync_n;

  // Initialization sequence
  rshb_pkg::rshb_init_t init_reg;
  rshb_pkg::rshb_init_t init_next;
  logic [7:0]           cnt_reg;
  logic [7:0]           cnt_next;
  logic                 fail_n_reg;
  logic                 fail_n_next;

  always_comb
  begin
    init_next   = init_reg;
    cnt_next    = cnt_reg;
    fail_n_next = fail_n_reg;
    case (init_reg)
      rshb_pkg::RSHB_INIT_RESET:
      begin
        // Sampled values at the first cycle after reset release
        if (!lk_reg)
          init_next = rshb_pkg::RSHB_INIT_DEBUG;
        else if (st_reg)
        begin
          init_next = rshb_pkg::RSHB_INIT_SELFTEST;
          cnt_next  = rshb_pkg::SELFTEST_CYC;
        end
        else
        begin
          init_next = rshb_pkg::RSHB_INIT_CONFTEST;
          cnt_next  = rshb_pkg::CONFTEST_CYC;
        end
      end
      rshb_pkg::RSHB_INIT_SELFTEST:
      begin
        if (cnt_reg != rshb_pkg::CNT_ZERO)
          cnt_next = cnt_reg - rshb_pkg::CNT_ONE;
        else if (selftest_ok)
        begin
          init_next = rshb_pkg::RSHB_INIT_CONFTEST;
          cnt_next  = rshb_pkg::CONFTEST_CYC;
        end
        else
          init_next = rshb_pkg::RSHB_INIT_FAILED;
      end
      rshb_pkg::RSHB_INIT_CONFTEST:
      begin
        if (cnt_reg != rshb_pkg::CNT_ZERO)
          cnt_next = cnt_reg - rshb_pkg::CNT_ONE;
        else if (conftest_ok)
        begin
          init_next   = rshb_pkg::RSHB_INIT_RUN;
          fail_n_next = 1'b1;
        end
        else
          init_next = rshb_pkg::RSHB_INIT_FAILED;
      end
      rshb_pkg::RSHB_INIT_RUN:
        init_next = rshb_pkg::RSHB_INIT_RUN;
      rshb_pkg::RSHB_INIT_FAILED:
        init_next = rshb_pkg::RSHB_INIT_FAILED;
      rshb_pkg::RSHB_INIT_DEBUG:
        init_next = rshb_pkg::RSHB_INIT_DEBUG;
      default:
        init_next = rshb_pkg::RSHB_INIT_RESET;
    endcase
  end

  // Fail output is low (asserted) from reset until the tests pass
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      init_reg   <= rshb_pkg::RSHB_INIT_RESET;
      cnt_reg    <= rshb_pkg::CNT_ZERO;
      fail_n_reg <= 1'b0;
    end
    else
    begin
      init_reg   <= init_next;
      cnt_reg    <= cnt_next;
      fail_n_reg <= fail_n_next;
    end
  end

  logic dbg;
  assign dbg = (init_reg == rshb_pkg::RSHB_INIT_DEBUG);

  // Bus ownership; a request is honoured during reset and while halted
  rshb_pkg::rshb_bus_t bus_reg;
  rshb_pkg::rshb_bus_t bus_next;
  logic                grant_reg;
  logic                grant_next;
  logic                lock_drv;

  // Lock is only driven in the run state of the init sequence, halted or not
  assign lock_drv = core_lock && (init_reg == rshb_pkg::RSHB_INIT_RUN);

  always_comb
  begin
    bus_next   = bus_reg;
    grant_next = grant_reg;
    case (bus_reg)
      rshb_pkg::RSHB_BUS_IDLE, rshb_pkg::RSHB_BUS_ADDR:
      begin
        bus_next = (core_addr_start && !in_reset && core_run)
                 ? rshb_pkg::RSHB_BUS_ADDR : rshb_pkg::RSHB_BUS_IDLE;
        if (req_reg && !lock_drv && !dbg)
        begin
          bus_next   = rshb_pkg::RSHB_BUS_HELD;
          grant_next = 1'b1;
        end
      end
      rshb_pkg::RSHB_BUS_HELD:
      begin
        if (!req_reg)
        begin
          grant_next = 1'b0;
          bus_next   = (core_bus_pending && !in_reset && core_run)
                     ? rshb_pkg::RSHB_BUS_ADDR : rshb_pkg::RSHB_BUS_IDLE;
        end
      end
      default:
      begin
        bus_next   = rshb_pkg::RSHB_BUS_IDLE;
        grant_next = 1'b0;
      end
    endcase
  end

  // No reset: a reset here would block the grant that reset must allow.
  // An unknown or stray state falls into the default branch and settles
  // to idle within one edge, whatever the request synchronizer holds.
  always_ff @(posedge clk)
  begin
    bus_reg   <= bus_next;
    grant_reg <= grant_next;
  end

  // Stall warning: core, out of reset and not halted, has work waiting while the bus is held or requested
  logic stall_reg;
  logic stall_next;

  always_comb
  begin
    stall_next = core_bus_pending && !in_reset && !core_halted &&
                 (bus_reg == rshb_pkg::RSHB_BUS_HELD || req_reg);
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      stall_reg <= 1'b0;
    else
      stall_reg <= stall_next;
  end

  // Bus pins: idle in reset, floated when held or in debug isolation
  rshb_pkg::rshb_buspin_t pins_reg;
  rshb_pkg::rshb_buspin_t pins_next;
  logic                   held;

  assign held = (bus_next == rshb_pkg::RSHB_BUS_HELD);

  always_comb
  begin
    pins_next.ad      = rshb_pkg::AD_IDLE;
    pins_next.ad_oe   = 1'b1;
    pins_next.ads_n   = rshb_pkg::CTRL_IDLE_N;
    pins_next.den_n   = rshb_pkg::CTRL_IDLE_N;
    pins_next.blast_n = rshb_pkg::CTRL_IDLE_N;
    pins_next.ctrl_oe = 1'b1;
    if (held || dbg)
    begin
      pins_next.ad_oe   = 1'b0;
      pins_next.ctrl_oe = 1'b0;
    end
    else if (!in_reset && init_reg == rshb_pkg::RSHB_INIT_RUN)
    begin
      pins_next.ad      = core_bus.ad;
      pins_next.ad_oe   = core_bus.ad_oe;
      pins_next.ads_n   = core_bus.ads_n;
      pins_next.den_n   = core_bus.den_n;
      pins_next.blast_n = core_bus.blast_n;
    end
  end

  // No reset: a grant given in reset must float the pins; with reset held
  // the idle values above reach the pins on the next edge
  always_ff @(posedge clk)
    pins_reg <= pins_next;

  // Lock output active low; a weak pull keeps it high while not driven
  logic lock_oe_reg;
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      lock_oe_reg <= 1'b0;
    else
      lock_oe_reg <= lock_drv && !dbg && !held;
  end

  assign bus_grant_ack             = grant_reg;
  assign stall_warning             = stall_reg;
  assign atomic_lock_debug_pin_out = 1'b0;
  assign atomic_lock_debug_pin_oe  = lock_oe_reg;
  assign fail_n                    = fail_n_reg;
  assign core_run   = (init_reg == rshb_pkg::RSHB_INIT_RUN) && !core_halted;
  assign core_reset = in_reset;
  assign debug_mode = dbg;
  assign selftest_active = (init_reg == rshb_pkg::RSHB_INIT_SELFTEST);
  assign conftest_active = (init_reg == rshb_pkg::RSHB_INIT_CONFTEST);
  assign bus_pins   = pins_reg;

endmodule // rshb_ctrl

// File: common/rshb_pkg.sv
// Package for the reset, self-test and bus hold control block
package rshb_pkg;

  // Timing of the clock and the reset hold times the system must respect
  localparam int CLK_PERIOD_NS       = 25;
  localparam int POWERUP_RESET_CYC   = 10000;
  localparam int WARM_RESET_CYC      = 15;

  // Length of the internal self-test and bus confidence test phases
  localparam logic [7:0] SELFTEST_CYC = 8'h20;
  localparam logic [7:0] CONFTEST_CYC = 8'h10;
  localparam logic [7:0] CNT_ZERO     = 8'h00;
  localparam logic [7:0] CNT_ONE      = 8'h01;

  // Bus width and the idle level of the address/data lines
  localparam int AD_W = 32;
  localparam logic [AD_W-1:0] AD_IDLE = 32'h0000_0000;

  // Idle levels of the control outputs
  localparam logic CTRL_IDLE_N = 1'b1;

  // Where the initialization sequence stands
  typedef enum logic [2:0] {
    RSHB_INIT_RESET,
    RSHB_INIT_SELFTEST,
    RSHB_INIT_CONFTEST,
    RSHB_INIT_RUN,
    RSHB_INIT_FAILED,
    RSHB_INIT_DEBUG
  } rshb_init_t;

  // Where the bus ownership stands
  typedef enum logic [1:0] {
    RSHB_BUS_IDLE,
    RSHB_BUS_ADDR,
    RSHB_BUS_HELD
  } rshb_bus_t;

  // Bus outputs that the core asks for, handed over as one group
  typedef struct packed {
    logic [AD_W-1:0] ad;
    logic            ad_oe;
    logic            ads_n;
    logic            den_n;
    logic            blast_n;
  } rshb_busreq_t;

  // Bus outputs as they leave the block toward the pins
  typedef struct packed {
    logic [AD_W-1:0] ad;
    logic            ad_oe;
    logic            ads_n;
    logic            den_n;
    logic            blast_n;
    logic            ctrl_oe;
  } rshb_buspin_t;

endpackage

// File: verif/rshb_master_model.sv
// Model of the external bus master that asks for the bus
`timescale 1ns/10ps
module rshb_master_model (
  input  wire logic clk,
  input  wire logic want,
  input  wire logic bus_grant_ack,
  input  wire logic stall_warning,
  output logic      bus_req,
  output logic      owned,
  output logic      give_back
);
  initial bus_req = 1'b0;
  // Request moves just after the edge and stands until told to drop
  always @(posedge clk)
    bus_req <= #2 want;
  assign owned = bus_req && bus_grant_ack;
  // Arbiter hint: an owning master should yield once a stall is threatened
  assign give_back = owned && stall_warning;
endmodule // rshb_master_model

// File: verif/rshb_ctrl_asserts.sv
// Checker of grant, reset idle and init timing at the control's ports
`timescale 1ns/10ps
module rshb_ctrl_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bus_req,
  input wire logic core_lock,
  input wire logic core_halted,
  input wire logic core_bus_pending,
  input wire logic selftest_ok,
  input wire logic conftest_ok,
  input wire logic bus_grant_ack,
  input wire logic stall_warning,
  input wire logic atomic_lock_debug_pin_oe,
  input wire logic fail_n,
  input wire logic core_run,
  input wire logic core_reset,
  input wire logic debug_mode,
  input wire logic selftest_active,
  input wire logic conftest_active,
  input wire rshb_pkg::rshb_buspin_t bus_pins
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_st_done;
    ##33 (conftest_active && !selftest_active);
  endsequence
  sequence s_ct_done;
    ##17 (!conftest_active && core_run);
  endsequence
  property p_grant_rise;
    ($rose(bus_req) && !core_lock && !debug_mode) ##1
    (bus_req && !core_lock && !debug_mode)[*5] |-> bus_grant_ack;
  endproperty
  property p_grant_fall;
    $fell(bus_req) ##1 (!bus_req)[*5] |-> !bus_grant_ack;
  endproperty
  property p_float;
    bus_grant_ack |-> !bus_pins.ad_oe && !bus_pins.ctrl_oe;
  endproperty
  property p_no_grant_lock;
    atomic_lock_debug_pin_oe |-> !bus_grant_ack;
  endproperty
  property p_reset_idle;
    core_reset && !bus_grant_ack |-> bus_pins.ads_n && bus_pins.den_n
      && bus_pins.blast_n && !fail_n && !stall_warning;
  endproperty
  property p_stall;
    stall_warning |-> $past(core_bus_pending) && !$past(core_halted);
  endproperty
  property p_debug;
    debug_mode && $past(debug_mode) |-> !bus_grant_ack
      && !bus_pins.ad_oe && !bus_pins.ctrl_oe;
  endproperty
  property p_st_len;
    $rose(selftest_active) && selftest_ok |-> s_st_done;
  endproperty
  property p_ct_len;
    $rose(conftest_active) && conftest_ok |-> s_ct_done;
  endproperty
  a_grant_rise: assert property (p_grant_rise)
    else $error("grant missing after request");
  a_grant_fall: assert property (p_grant_fall)
    else $error("grant kept after request drop");
  a_float: assert property (p_float)
    else $error("bus driven while granted");
  a_no_grant_lock: assert property (p_no_grant_lock)
    else $error("grant during lock");
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle in reset");
  a_stall: assert property (p_stall)
    else $error("stall warning without cause");
  a_debug: assert property (p_debug)
    else $error("outputs driven in debug mode");
  a_st_len: assert property (p_st_len)
    else $error("self-test phase length wrong");
  a_ct_len: assert property (p_ct_len)
    else $error("confidence test length wrong");
endmodule // rshb_ctrl_asserts

bind rshb_ctrl rshb_ctrl_asserts i_chk (
  .clk(clk), .rst_n(rst_n), .bus_req(bus_req), .core_lock(core_lock),
  .core_halted(core_halted), .core_bus_pending(core_bus_pending),
  .selftest_ok(selftest_ok), .conftest_ok(conftest_ok),
  .bus_grant_ack(bus_grant_ack), .stall_warning(stall_warning),
  .atomic_lock_debug_pin_oe(atomic_lock_debug_pin_oe), .fail_n(fail_n),
  .core_run(core_run), .core_reset(core_reset), .debug_mode(debug_mode),
  .selftest_active(selftest_active), .conftest_active(conftest_active),
  .bus_pins(bus_pins)
);

// File: verif/rshb_ctrl_tb.sv
// Testbench of the reset, self-test and bus hold control
`timescale 1ns/10ps
module rshb_ctrl_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic want = 1'b0;
  logic selftest_select = 1'b1;
  logic lock_in = 1'b1;
  logic core_lock = 1'b0;
  logic core_halted = 1'b0;
  logic core_bus_pending = 1'b0;
  logic selftest_ok = 1'b1;
  logic conftest_ok = 1'b1;
  logic give_back;
  logic bus_req, owned, bus_grant_ack, stall_warning, lock_out, lock_oe;
  logic fail_n, core_run, core_reset, debug_mode, st_act, ct_act;
  rshb_pkg::rshb_busreq_t core_bus = '{32'h5a5a_5a5a, 1'b1, 1'b0, 1'b0, 1'b0};
  rshb_pkg::rshb_buspin_t bus_pins;
  int error_cnt = 0;
  int n_compared = 0;

  rshb_master_model i_master (.clk(clk), .want(want),
    .bus_grant_ack(bus_grant_ack), .stall_warning(stall_warning),
    .bus_req(bus_req), .owned(owned), .give_back(give_back));
  rshb_ctrl i_dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
    .selftest_select(selftest_select), .atomic_lock_debug_pin_in(lock_in),
    .core_lock(core_lock), .core_halted(core_halted),
    .core_bus_pending(core_bus_pending), .core_addr_start(1'b0),
    .selftest_ok(selftest_ok), .conftest_ok(conftest_ok),
    .core_bus(core_bus),
    .bus_grant_ack(bus_grant_ack), .stall_warning(stall_warning),
    .atomic_lock_debug_pin_out(lock_out), .atomic_lock_debug_pin_oe(lock_oe),
    .fail_n(fail_n), .core_run(core_run), .core_reset(core_reset),
    .debug_mode(debug_mode), .selftest_active(st_act),
    .conftest_active(ct_act), .bus_pins(bus_pins));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Warm reset length; the device itself does not police it
  task automatic do_reset(input logic st, input logic lk);
    rst_n = 1'b0;
    selftest_select = st;
    lock_in = lk;
    cyc(rshb_pkg::WARM_RESET_CYC);
    rst_n = 1'b1;
    cyc(1);
    chk("core_reset", core_reset, 1'b1);
    selftest_select = !st;
  endtask
  task automatic t_reset();
    rst_n = 1'b0;
    cyc(rshb_pkg::POWERUP_RESET_CYC);
    chk("ads_n", bus_pins.ads_n, 1'b1);
    chk("ad", bus_pins.ad, rshb_pkg::AD_IDLE);
    chk("fail_n", fail_n, 1'b0);
    want = 1'b1;
    cyc(7);
    chk("grant", bus_grant_ack, 1'b1);
    chk("ctrl_oe", bus_pins.ctrl_oe, 1'b0);
    want = 1'b0;
    cyc(7);
    chk("grant", bus_grant_ack, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_init(input logic st);
    int ns;
    int nc;
    ns = 0;
    nc = 0;
    do_reset(st, 1'b1);
    repeat (80)
    begin
      cyc(1);
      ns += (st_act === 1'b1) ? 1 : 0;
      nc += (ct_act === 1'b1) ? 1 : 0;
    end
    chk("selftest_cyc", ns, st ? 33 : 0);
    chk("conftest_cyc", nc, 17);
    chk("fail_n", fail_n, 1'b1);
    chk("core_run", core_run, 1'b1);
    $display("test init done");
  endtask
  task automatic t_bus();
    core_halted = 1'b1;
    core_bus_pending = 1'b1;
    want = 1'b1;
    cyc(7);
    chk("owned", owned, 1'b1);
    chk("ad_oe", bus_pins.ad_oe, 1'b0);
    chk("stall", stall_warning, 1'b0);
    chk("give_back", give_back, 1'b0);
    core_halted = 1'b0;
    cyc(2);
    chk("stall", stall_warning, 1'b1);
    chk("give_back", give_back, 1'b1);
    want = 1'b0;
    cyc(7);
    chk("ctrl_oe", bus_pins.ctrl_oe, 1'b1);
    core_lock = 1'b1;
    cyc(2);
    want = 1'b1;
    cyc(7);
    chk("lock_oe", lock_oe, 1'b1);
    chk("grant", bus_grant_ack, 1'b0);
    chk("lock_out", lock_out, 1'b0);
    core_lock = 1'b0;
    want = 1'b0;
    core_bus_pending = 1'b0;
    cyc(7);
    $display("test bus done");
  endtask
  task automatic t_fail_debug();
    selftest_ok = 1'b0;
    do_reset(1'b1, 1'b1);
    cyc(80);
    chk("fail_n", fail_n, 1'b0);
    chk("core_run", core_run, 1'b0);
    selftest_ok = 1'b1;
    conftest_ok = 1'b0;
    do_reset(1'b0, 1'b1);
    cyc(40);
    chk("fail_n", fail_n, 1'b0);
    chk("core_run", core_run, 1'b0);
    conftest_ok = 1'b1;
    do_reset(1'b1, 1'b0);
    want = 1'b1;
    cyc(10);
    chk("debug", debug_mode, 1'b1);
    chk("ctrl_oe", bus_pins.ctrl_oe, 1'b0);
    chk("grant", bus_grant_ack, 1'b0);
    $display("test fail and debug done");
  endtask

  initial
  begin
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    cyc(3);
    rst_n = 1'b1;
    cyc(5);
    t_reset();
    t_init(1'b1);
    t_init(1'b0);
    t_bus();
    t_fail_debug();
    summarize();
  end
  initial
  begin
    // Tests take about 10,400 cycles, most of it the power-up reset
    #(16000 * rshb_pkg::CLK_PERIOD_NS);
    error_cnt++;
    summarize();
  end
endmodule // rshb_ctrl_tb
